//--- core/fifo_rd_pkg.sv
package fifo_rd_pkg;
    localparam int DATA_W = 18;
    localparam int NARROW_W = 9;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int OFFSET_W = 12;
    localparam logic [17:0] OUT_RESET = 18'h00000;
    localparam logic [11:0] EMPTY_OFS_RESET = 12'h007;
    localparam logic [11:0] FULL_OFS_RESET = 12'h007;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WORD = 2'b01,
        RD_OFS_E = 2'b11,
        RD_OFS_F = 2'b10
    } rd_state_t;

    typedef struct packed {
        logic fallthrough_timing;
        logic async_read;
        logic narrow_out;
        logic serial_prog;
    } mode_cfg_t;

    typedef struct packed {
        logic [11:0] empty_ofs;
        logic [11:0] full_ofs;
    } offsets_t;
endpackage

//--- core/word_fifo.sv
`timescale 1ns/1ps
// Circular store with honest full and empty; clear resets the pointers only.
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    input wire logic rewind,
    input wire logic [AW-1:0] rewind_ptr,
    output logic [AW-1:0] rd_ptr
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem[rd_q[AW-1:0]];
    assign rd_ptr = rd_q[AW-1:0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (clear) begin
            wr_d = '0;
            rd_d = '0;
        end else begin
            if (push) begin
                wr_d = wr_q + 1'b1;
            end
            if (rewind) begin
                // Step back by the distance read since the target, so a full
                // queue rewound to its start stays full instead of looking empty
                rd_d = rd_q - {1'b0, rd_q[AW-1:0] - rewind_ptr};
            end else if (pop) begin
                rd_d = rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

//--- core/fifo_read_port_control.sv
`timescale 1ns/1ps
// Summary of operation
// - Partial reset zeroes pointers and output register
// - Partial reset keeps modes and offsets
// - Output is 18 or 9 bits wide
// - Synchronous read takes one word per edge
// - Load select low reads offset registers instead
// - Strobe reads one word; enable held low
// - Chip select gates reads and output drive
// - Chip select ignored in reset; enable drives
// - Read enable qualifies every synchronous read
// - Retransmit rewinds read pointer, shows empty for one cycle
// - Retransmit goes to mark when set
// - Serial enable shifts serial bit into offsets
// - Shared pin picks timing then serial data
// - Mark records current read pointer
module fifo_read_port_control #(
    parameter int DATA_W = fifo_rd_pkg::DATA_W,
    parameter int DEPTH = fifo_rd_pkg::DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic async_read_sel,
    input wire logic narrow_out_sel,
    input wire logic offset_load_select_n,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic write_valid,
    output logic write_ready,
    input wire logic read_enable_n,
    input wire logic read_strobe,
    input wire logic read_select_n,
    input wire logic output_enable_n,
    input wire logic retransmit_req,
    input wire logic mark_req,
    input wire logic serial_clk,
    input wire logic offset_shift_enable_n,
    input wire logic fallthrough_or_serial_in,
    output logic [DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    output logic empty_flag_n,
    output logic fallthrough_timing,
    output logic [fifo_rd_pkg::OFFSET_W-1:0] empty_offset,
    output logic [fifo_rd_pkg::OFFSET_W-1:0] full_offset
);
    localparam int AW = $clog2(DEPTH);

    fifo_rd_pkg::mode_cfg_t cfg_q, cfg_d;
    fifo_rd_pkg::offsets_t ofs_q, ofs_d;
    fifo_rd_pkg::rd_state_t st_q, st_d;
    logic [DATA_W-1:0] out_q, out_d;
    logic [AW-1:0] mark_q, mark_d;
    logic mark_set_q, mark_set_d;
    logic sel_q, sel_d;
    logic strobe_q, strobe_d;
    logic sclk_q, sclk_d;
    logic in_reset;
    logic fifo_clear;
    logic [DATA_W-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic [AW-1:0] fifo_rd_ptr;
    logic rd_event;
    logic rewind;
    logic sclk_rise;
    logic strobe_rise;
    logic retx_hold_q, retx_hold_d;
    logic read_ok;
    logic ofs_read;
    logic mem_read;
    logic [AW-1:0] rewind_target;

    assign in_reset = !master_reset_n || !partial_reset_n;
    assign fifo_clear = in_reset;
    assign rewind = retransmit_req && !in_reset;
    assign sclk_rise = serial_clk && !sclk_q;
    assign strobe_rise = read_strobe && !strobe_q;

    // Strobe edge taken on core_clk; enable must stay low in this mode
    always_comb begin
        strobe_d = read_strobe;
    end

    always_comb begin
        sclk_d = serial_clk;
    end

    always_comb begin
        if (cfg_q.async_read) begin
            rd_event = strobe_rise && !read_enable_n;
        end else begin
            rd_event = !read_enable_n;
        end
    end

    // Chip select registered, so its effect lands one edge later
    always_comb begin
        sel_d = !read_select_n;
    end

    assign read_ok = rd_event && sel_q && !in_reset;
    assign ofs_read = read_ok && !offset_load_select_n;
    assign mem_read = read_ok && offset_load_select_n;
    // Reads wait out a rewind, since the flag shows empty for that cycle
    assign fifo_pop = mem_read && !rewind && !retx_hold_q;

    always_comb begin
        rewind_target = '0;
        if (mark_set_q) begin
            rewind_target = mark_q;
        end
    end

    word_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .clear(fifo_clear),
        .in_data(write_data),
        .in_valid(write_valid),
        .in_ready(write_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .rewind(rewind),
        .rewind_ptr(rewind_target),
        .rd_ptr(fifo_rd_ptr)
    );

    always_comb begin
        cfg_d = cfg_q;
        if (!master_reset_n) begin
            cfg_d.fallthrough_timing = fallthrough_or_serial_in && !async_read_sel;
            cfg_d.async_read = async_read_sel;
            cfg_d.narrow_out = narrow_out_sel;
            cfg_d.serial_prog = offset_load_select_n;
        end
    end

    always_comb begin
        ofs_d = ofs_q;
        if (!master_reset_n) begin
            ofs_d.empty_ofs = fifo_rd_pkg::EMPTY_OFS_RESET;
            ofs_d.full_ofs = fifo_rd_pkg::FULL_OFS_RESET;
        end else if (sclk_rise && !offset_shift_enable_n) begin
            // Partial reset leaves offsets alone
            ofs_d = {ofs_q[2*fifo_rd_pkg::OFFSET_W-2:0], fallthrough_or_serial_in};
        end
    end

    always_comb begin
        mark_d = mark_q;
        mark_set_d = mark_set_q;
        if (in_reset) begin
            mark_set_d = 1'b0;
        end else if (mark_req) begin
            mark_d = fifo_rd_ptr;
            mark_set_d = 1'b1;
        end
    end

    always_comb begin
        retx_hold_d = 1'b0;
        if (rewind) begin
            retx_hold_d = 1'b1;
        end
    end

    // Offsets come out empty then full, one word per qualified read
    always_comb begin
        st_d = st_q;
        out_d = out_q;
        if (in_reset) begin
            st_d = fifo_rd_pkg::RD_IDLE;
            out_d = fifo_rd_pkg::OUT_RESET;
        end else if (ofs_read) begin
            case (st_q)
                fifo_rd_pkg::RD_OFS_E: begin
                    st_d = fifo_rd_pkg::RD_OFS_F;
                    out_d = DATA_W'(ofs_q.full_ofs);
                end
                fifo_rd_pkg::RD_OFS_F: begin
                    st_d = fifo_rd_pkg::RD_OFS_E;
                    out_d = DATA_W'(ofs_q.empty_ofs);
                end
                default: begin
                    st_d = fifo_rd_pkg::RD_OFS_E;
                    out_d = DATA_W'(ofs_q.empty_ofs);
                end
            endcase
        end else if (mem_read) begin
            if (fifo_pop && fifo_valid) begin
                st_d = fifo_rd_pkg::RD_WORD;
                out_d = fifo_out;
            end else begin
                st_d = fifo_rd_pkg::RD_IDLE;
            end
        end
        if (cfg_q.narrow_out) begin
            out_d[DATA_W-1:fifo_rd_pkg::NARROW_W] = '0;
        end
    end

    // Modes and offsets are loaded by master reset; rstn alone clears modes and restores default offsets
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= strobe_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ofs_q <= {fifo_rd_pkg::EMPTY_OFS_RESET, fifo_rd_pkg::FULL_OFS_RESET};
        end else begin
            ofs_q <= ofs_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= fifo_rd_pkg::RD_IDLE;
            out_q <= fifo_rd_pkg::OUT_RESET;
        end else begin
            st_q <= st_d;
            out_q <= out_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mark_q <= '0;
            mark_set_q <= 1'b0;
        end else begin
            mark_q <= mark_d;
            mark_set_q <= mark_set_d;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            retx_hold_q <= 1'b0;
        end else begin
            retx_hold_q <= retx_hold_d;
        end
    end

    assign read_data_out = out_q;

    // During reset only output enable governs drive
    always_comb begin
        read_data_oe = 1'b0;
        if (!output_enable_n) begin
            if (in_reset) begin
                read_data_oe = 1'b1;
            end else begin
                read_data_oe = sel_q;
            end
        end
    end

    // A rewind shows empty for one cycle while reads are held off
    always_comb begin
        empty_flag_n = fifo_valid;
        if (retx_hold_q) begin
            empty_flag_n = 1'b0;
        end
    end

    assign fallthrough_timing = cfg_q.fallthrough_timing;
    assign empty_offset = ofs_q.empty_ofs;
    assign full_offset = ofs_q.full_ofs;
endmodule

//--- sim/fifo_read_port_control_properties.sv
`timescale 1ns/1ps
module fifo_read_port_control_properties #(
    parameter int DATA_W = 18,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic offset_load_select_n,
    input wire logic read_enable_n,
    input wire logic read_select_n,
    input wire logic output_enable_n,
    input wire logic retransmit_req,
    input wire logic mark_req,
    input wire logic offset_shift_enable_n,
    input wire logic [DATA_W-1:0] read_data_out,
    input wire logic read_data_oe,
    input wire logic empty_flag_n,
    input wire logic fallthrough_timing,
    input wire logic [11:0] empty_offset,
    input wire logic [11:0] full_offset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic run;
    assign run = master_reset_n && partial_reset_n;
    sequence s_retx;
        retransmit_req && run && !mark_req ##1 1'b1;
    endsequence
    sequence s_preset;
        !partial_reset_n && master_reset_n && offset_shift_enable_n;
    endsequence
    a_preset_clears: assert property (!partial_reset_n |=> read_data_out == '0)
        else $error("output not cleared by partial reset");
    a_preset_keeps: assert property (s_preset |=> $stable({empty_offset, fallthrough_timing}))
        else $error("settings lost in partial reset");
    a_reset_drive: assert property (!run && !output_enable_n |-> read_data_oe)
        else $error("outputs not driven in reset");
    a_oe_off: assert property (output_enable_n |-> !read_data_oe)
        else $error("outputs driven while disabled");
    a_desel_off: assert property (run && $past(read_select_n) |-> !read_data_oe)
        else $error("outputs driven while deselected");
    a_idle_holds: assert property (read_enable_n && run |=> $stable(read_data_out))
        else $error("output moved without enable");
    a_empty_holds: assert property (!empty_flag_n && offset_load_select_n && run
        |=> $stable(read_data_out))
        else $error("output moved on empty read");
    a_retx_flag: assert property (s_retx |-> !empty_flag_n)
        else $error("empty flag after retransmit");
    a_shift_idle: assert property (offset_shift_enable_n && master_reset_n
        |=> $stable({empty_offset, full_offset}))
        else $error("offsets moved without shift enable");
endmodule
bind fifo_read_port_control fifo_read_port_control_properties #(.DATA_W(DATA_W), .DEPTH(DEPTH))
    chk_i (.core_clk, .rstn, .master_reset_n, .partial_reset_n, .offset_load_select_n,
    .read_enable_n, .read_select_n, .output_enable_n, .retransmit_req, .mark_req,
    .offset_shift_enable_n, .read_data_out, .read_data_oe, .empty_flag_n, .fallthrough_timing,
    .empty_offset, .full_offset);

//--- sim/read_side_model.sv
`timescale 1ns/1ps
module read_side_model (
    input wire logic rd_go,
    input wire logic ofs_go,
    input wire logic desel,
    input wire logic async_mode,
    output logic read_enable_n,
    output logic read_strobe,
    output logic read_select_n,
    output logic offset_load_select_n
);
    // Strobe mode pins enable low so only strobe rises can read
    assign read_enable_n = async_mode ? 1'b0 : !rd_go;
    assign read_strobe = async_mode & rd_go;
    assign read_select_n = desel;
    assign offset_load_select_n = !ofs_go;
endmodule

//--- sim/fifo_read_port_control_bench.sv
`timescale 1ns/1ps
module fifo_read_port_control_bench;
    logic core_clk, rstn, master_reset_n, partial_reset_n, async_read_sel, narrow_out_sel;
    logic write_valid, write_ready, read_enable_n, read_strobe, read_select_n, output_enable_n;
    logic retransmit_req, mark_req, serial_clk, offset_shift_enable_n, fallthrough_or_serial_in;
    logic read_data_oe, empty_flag_n, fallthrough_timing, offset_load_select_n;
    logic rd_go, ofs_go, desel, async_mode;
    logic [17:0] write_data, read_data_out;
    logic [11:0] empty_offset, full_offset;
    int n_mismatch, checks;
    fifo_read_port_control uut (.core_clk, .rstn, .master_reset_n, .partial_reset_n,
        .async_read_sel, .narrow_out_sel, .offset_load_select_n, .write_data, .write_valid,
        .write_ready, .read_enable_n, .read_strobe, .read_select_n, .output_enable_n,
        .retransmit_req, .mark_req, .serial_clk, .offset_shift_enable_n,
        .fallthrough_or_serial_in, .read_data_out, .read_data_oe, .empty_flag_n,
        .fallthrough_timing, .empty_offset, .full_offset);
    read_side_model partner (.rd_go, .ofs_go, .desel, .async_mode, .read_enable_n,
        .read_strobe, .read_select_n, .offset_load_select_n);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic push(input logic [17:0] d);
        cyc(1);
        write_data = d;
        write_valid = 1'b1;
        cyc(1);
        write_valid = 1'b0;
    endtask
    task automatic rd(input logic ofs);
        cyc(1);
        rd_go = 1'b1;
        ofs_go = ofs;
        cyc(1);
        {rd_go, ofs_go} = 2'h0;
        cyc(1);
    endtask
    task automatic ctl(input logic m);
        cyc(1);
        mark_req = m;
        retransmit_req = !m;
        cyc(1);
        {mark_req, retransmit_req} = 2'h0;
    endtask
    task automatic mreset(input logic a, input logic n, input logic f);
        cyc(1);
        {async_read_sel, async_mode, narrow_out_sel} = {a, a, n};
        fallthrough_or_serial_in = f;
        master_reset_n = 1'b0;
        cyc(2);
        master_reset_n = 1'b1;
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {rstn, async_read_sel, narrow_out_sel, write_valid, retransmit_req, mark_req} = '0;
        {serial_clk, rd_go, ofs_go, desel, async_mode, output_enable_n} = '0;
        {master_reset_n, partial_reset_n, offset_shift_enable_n} = 3'h7;
        {fallthrough_or_serial_in, write_data, n_mismatch, checks} = '0;
        cyc(20);
        rstn = 1'b1;
        mreset(1'b0, 1'b0, 1'b1);
        chk({17'h0, fallthrough_timing}, 18'h1);
        for (int i = 0; i < 16; i++)
            push(18'h2a5a0 + 18'(i));
        chk({17'h0, write_ready}, 18'h0);
        rd(1'b0);
        chk(read_data_out, 18'h2a5a0);
        rd(1'b1);
        chk(read_data_out, 18'h00007);
        rd(1'b0);
        chk(read_data_out, 18'h2a5a1);
        ctl(1'b0);
        chk({17'h0, empty_flag_n}, 18'h0);
        rd(1'b0);
        chk(read_data_out, 18'h2a5a0);
        ctl(1'b1);
        rd(1'b0);
        rd(1'b0);
        ctl(1'b0);
        rd(1'b0);
        chk(read_data_out, 18'h2a5a1);
        desel = 1'b1;
        rd(1'b0);
        chk(read_data_out, 18'h2a5a1);
        chk({17'h0, read_data_oe}, 18'h0);
        offset_shift_enable_n = 1'b0;
        // Serial clock is held low between shifts, as the far side would
        for (int i = 23; i >= 0; i--) begin
            fallthrough_or_serial_in = 1'(24'h5a3c81 >> i);
            cyc(1);
            serial_clk = 1'b1;
            cyc(1);
            serial_clk = 1'b0;
        end
        offset_shift_enable_n = 1'b1;
        cyc(2);
        chk({empty_offset, 6'h00}, {12'h5a3, 6'h00});
        chk({6'h00, full_offset}, 18'h00c81);
        partial_reset_n = 1'b0;
        cyc(1);
        chk({17'h0, read_data_oe}, 18'h1);
        partial_reset_n = 1'b1;
        cyc(1);
        chk(read_data_out, 18'h0);
        chk({17'h0, empty_flag_n}, 18'h0);
        chk({6'h00, empty_offset}, 18'h005a3);
        desel = 1'b0;
        mreset(1'b1, 1'b1, 1'b1);
        chk({17'h0, fallthrough_timing}, 18'h0);
        push(18'h3ffff);
        push(18'h2aaaa);
        rd(1'b0);
        chk(read_data_out, 18'h001ff);
        rd(1'b0);
        chk(read_data_out, 18'h000aa);
        finish_test;
    end
    initial begin
        #20000;
        n_mismatch++;
        finish_test;
    end
endmodule
